// >>> bench/iad_peer_model.sv
// partner model: peer unit answering forwarded requests on the bus
// assumes one forwarded pulse at a time, steered by the bench
`timescale 1ns/1ps
module iad_peer_model (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // forwarded request and steering
  input  wire logic               fwd_i,
  input  wire logic               mute_i,
  input  wire logic         [3:0] dly_i,
  input  wire iad_pkg::iad_kind_t kind_i,
  // reply
  output logic                    rsp_o,
  output iad_pkg::iad_kind_t      kind_o
);
  import iad_pkg::*;
  logic       busy_q;
  logic [3:0] cnt_q;
  // any reply kind
  // a muted peer takes no new forwarded request, so only the timeout can end it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_q <= 1'h0;
      cnt_q  <= 4'h0;
      rsp_o  <= 1'h0;
      kind_o <= K_ACCEPT;
    end else begin
      rsp_o  <= 1'h0;
      // idle kind lines toggle so a stale value never passes
      kind_o <= iad_kind_t'(~kind_o);
      if (fwd_i && !mute_i) begin
        busy_q <= 1'h1;
        cnt_q  <= dly_i;
      end else if (busy_q && cnt_q == 4'h0) begin
        busy_q <= 1'h0;
        rsp_o  <= 1'h1;
        kind_o <= kind_i;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule

// >>> bench/interagent_address_decode_tb_top.sv
// testbench: apb setup, serving rows, then local bus and apb cases
// assumes the peer model answers forwarded requests
`timescale 1ns/1ps
module interagent_address_decode_tb_top;
  import iad_pkg::*;
  typedef struct packed {
    logic [31:0] a;
    logic [2:0]  w;
    logic [3:0]  q;
    logic [1:0]  b;
    logic        v;
    iad_kind_t   k;
    logic [1:0]  t;
    logic        r;
  } iad_row_t;
  logic        clk, rst, psel, pen, pwr, lreq, lwr, sreq, swr, mute;
  logic        prdy, perr, lrdy, lfail, fv, rv;
  logic [7:0]  paddr;
  logic [31:0] pwd, prd, ladr, ldat, sadr, sdat, fadr;
  logic [2:0]  lw, sw;
  logic [3:0]  sq, dly;
  logic [1:0]  sbuf, taken;
  iad_kind_t   pk, rk, lk;
  iad_reply_t  rep, lrep;
  iad_regop_t  rop;
  int          n_errors, checked, i;
  iad_row_t    rows [17];
  interagent_address_decode #(.TIMEOUT_CYCLES(8))
    u_interagent_address_decode (
    .CLK_SYS_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwd), .PRDATA_O(prd),
    .PREADY_O(prdy), .PSLVERR_O(perr), .LB_REQ_I(lreq), .LB_ADDR_I(ladr),
    .LB_WRITE_I(lwr), .LB_WORDS_I(lw), .LB_BE_I(ladr[3:0]), .LB_DATA_I(ldat),
    .LB_READY_O(lrdy), .LB_FAIL_O(lfail), .LB_KIND_O(lk),
    .SMB_FWD_VALID_O(fv), .SMB_FWD_ADDR_O(fadr), .SMB_FWD_WRITE_O(),
    .SMB_FWD_WORDS_O(), .SMB_FWD_DATA_O(), .SMB_RSP_VALID_I(rv),
    .SMB_RSP_KIND_I(rk), .SMB_REQ_I(sreq), .SMB_ADDR_I(sadr),
    .SMB_WRITE_I(swr), .SMB_WORDS_I(sw), .SMB_DATA_I(sdat),
    .SMB_LOCKED_READ_I(sq[3]), .SMB_SEG_LOCKED_I(sq[2]),
    .SMB_MMIO_I(sq[1]), .SMB_IO_BLOCKED_I(sq[0]), .SMB_BUF_FREE_I(sbuf),
    .SMB_REPLY_O(rep), .REG_OP_O(rop), .MSG_TAKEN_O(taken));
  iad_peer_model u_iad_peer_model (.clk_i(clk), .rst_i(rst), .fwd_i(fv),
    .mute_i(mute), .dly_i(dly), .kind_i(pk), .rsp_o(rv), .kind_o(rk));
  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task chk(input string s, input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task complete_run;
    if (n_errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           input logic [31:0] e, input logic er);
    int j;
    @(posedge clk);
    psel  <= 1'h1;
    pwr   <= w;
    paddr <= a;
    pwd   <= d;
    @(posedge clk);
    pen <= 1'h1;
    for (j = 0; j < 20; j++) begin
      @(posedge clk);
      if (prdy === 1'h1) break;
    end
    psel <= 1'h0;
    pen  <= 1'h0;
    chk("pready", j < 20, 1'h1);
    chk("pslverr", perr, er);
    if (!w) chk("prdata", prd, e);
  endtask
  // holds the request until answered or 40 cycles pass; ans low expects silence
  task lb(input logic [31:0] a, input logic [2:0] w, input logic ans,
          input logic rdy, input iad_kind_t k);
    int j;
    @(posedge clk);
    lreq <= 1'h1;
    ladr <= a;
    lw   <= w;
    for (j = 0; j < 40; j++) begin
      @(posedge clk);
      if (lrdy === 1'h1 || lfail === 1'h1) break;
    end
    lrep = rep;
    lreq <= 1'h0;
    chk("answered", j < 40, ans);
    if (ans) chk("ready", lrdy, rdy);
    if (ans) chk("lb kind", lk, k);
    repeat (2) @(posedge clk);
  endtask
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    complete_run;
  end
  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    {psel, pen, pwr, lreq, sreq, mute} = '0;
    {lwr, swr, rst} = 3'h7;
    {paddr, pwd, ladr, sadr, sq, dly, sbuf} = '0;
    {ldat, sdat, lw, sw} = {32'h1234abcd, 32'h5a5aa5a5, 3'h1, 3'h1};
    pk = K_ACCEPT;
    n_errors = 0;
    checked = 0;
    rows = '{
      '{32'hff314080, 3'h1, 4'h0, 2'h1, 1'h1, K_ACCEPT, 2'h1, 1'h0},
      '{32'hff314040, 3'h1, 4'h0, 2'h1, 1'h1, K_ACCEPT, 2'h1, 1'h0},
      '{32'hff314030, 3'h1, 4'h0, 2'h1, 1'h1, K_NACK, 2'h0, 1'h0},
      '{32'hff3141f0, 3'h1, 4'h0, 2'h2, 1'h1, K_NACK, 2'h0, 1'h0},
      '{32'hff316080, 3'h1, 4'h0, 2'h2, 1'h1, K_ACCEPT, 2'h2, 1'h0},
      '{32'hff316080, 3'h1, 4'h0, 2'h1, 1'h1, K_NACK, 2'h0, 1'h0},
      '{32'hff318080, 3'h1, 4'h0, 2'h3, 1'h0, K_ACCEPT, 2'h0, 1'h0},
      '{32'hfff14080, 3'h1, 4'h0, 2'h3, 1'h0, K_ACCEPT, 2'h0, 1'h0},
      '{32'h00001000, 3'h1, 4'hc, 2'h3, 1'h1, K_RETRY, 2'h0, 1'h0},
      '{32'h00001000, 3'h1, 4'h3, 2'h3, 1'h1, K_RETRY, 2'h0, 1'h0},
      '{32'h00001000, 3'h1, 4'h0, 2'h3, 1'h0, K_ACCEPT, 2'h0, 1'h0},
      '{32'hff214004, 3'h1, 4'h0, 2'h3, 1'h1, K_ACCEPT, 2'h0, 1'h1},
      '{32'hff214004, 3'h2, 4'h0, 2'h3, 1'h1, K_NACK, 2'h0, 1'h0},
      '{32'hff214204, 3'h1, 4'h0, 2'h3, 1'h1, K_ACCEPT, 2'h0, 1'h1},
      '{32'hff216004, 3'h1, 4'h0, 2'h3, 1'h0, K_ACCEPT, 2'h0, 1'h0},
      '{32'hff400008, 3'h1, 4'h0, 2'h3, 1'h1, K_ACCEPT, 2'h0, 1'h1},
      '{32'hff404008, 3'h1, 4'h0, 2'h3, 1'h0, K_ACCEPT, 2'h0, 1'h0}};
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    apb(1'h0, OFS_LOGID, 32'h0, 32'h0, 1'h0);
    apb(1'h1, OFS_HWID, 32'h3f, 32'h0, 1'h0);
    apb(1'h0, OFS_HWID, 32'h0, 32'h0, 1'h0);
    apb(1'h0, 8'h40, 32'h0, 32'h0, 1'h1);
    apb(1'h1, OFS_CTRL, 32'h3, 32'h0, 1'h0);
    apb(1'h0, OFS_CTRL, 32'h0, 32'h3, 1'h0);
    apb(1'h1, OFS_LOGID, 32'h5, 32'h0, 1'h0);
    apb(1'h1, OFS_ACC0, 32'h104, 32'h0, 1'h0);
    apb(1'h1, OFS_ACC1, 32'h100, 32'h0, 1'h0);
    for (i = 0; i < 17; i++) begin
      @(posedge clk);
      sreq <= 1'h1;
      {sadr, sw, sq, sbuf} <= {rows[i].a, rows[i].w, rows[i].q, rows[i].b};
      @(posedge clk);
      sreq <= 1'h0;
      @(negedge clk);
      chk("reply", rep.valid, rows[i].v);
      if (rows[i].v) chk("kind", rep.kind, rows[i].k);
      chk("taken", taken, rows[i].t);
      chk("regop", rop.valid, rows[i].r);
      if (rows[i].r) chk("index", rop.index, rows[i].a[9:2]);
      if (rows[i].r) chk("data", rop.data, rows[i].a[9] ? 32'h0 : sdat);
    end
    lb(32'hff214404, 3'h1, 1'h1, 1'h1, K_ACCEPT);
    chk("fwd addr", fadr, 32'hff214404);
    pk <= K_NACK;
    lb(32'hff314080, 3'h1, 1'h1, 1'h0, K_NACK);
    pk <= K_FAILED;
    dly <= 4'h3;
    lb(32'hff214404, 3'h1, 1'h1, 1'h0, K_FAILED);
    mute <= 1'h1;
    lb(32'hff214408, 3'h1, 1'h1, 1'h0, K_FAILED);
    chk("timeout reply", lrep, {1'h1, K_FAILED});
    lb(32'hff214804, 3'h1, 1'h0, 1'h0, K_ACCEPT);
    lb(32'hfff00000, 3'h1, 1'h0, 1'h0, K_ACCEPT);
    lb(32'hff000004, 3'h2, 1'h1, 1'h0, K_FAILED);
    apb(1'h0, OFS_STATUS, 32'h0, 32'h3, 1'h0);
    lb(32'hff000008, 3'h1, 1'h1, 1'h1, K_ACCEPT);
    apb(1'h1, OFS_CTRL, 32'h2, 32'h0, 1'h0);
    lb(32'hff314080, 3'h1, 1'h0, 1'h0, K_ACCEPT);
    apb(1'h1, OFS_AGSEL, 32'h1, 32'h0, 1'h0);
    sreq <= 1'h1;
    sadr <= 32'hff216004;
    @(posedge clk);
    sreq <= 1'h0;
    @(negedge clk);
    chk("test access", rop.valid, 1'h1);
    @(posedge clk);
    rst <= 1'h1;
    @(posedge clk);
    rst <= 1'h0;
    apb(1'h0, OFS_CTRL, 32'h0, 32'h0, 1'h0);
    complete_run;
  end
endmodule

// >>> rtl/iad_field_split.sv
// splits a 32-bit address into interagent fields
// assumes a plain combinational path; caller registers results
`timescale 1ns/1ps
module iad_field_split (
  // address in
  input  wire logic                [31:0] addr_i,
  // decoded out
  output logic                            is_iac_o,
  output iad_pkg::iad_fields_t            fields_o
);
  import iad_pkg::*;

  // (RL7) top byte all ones
  assign is_iac_o = (addr_i[ID_HI:ID_LO] == IAC_ID_VAL);
  // (RL8) four field split
  assign fields_o.ty                    = addr_i[TY_HI:TY_LO];
  assign fields_o.module_dest           = addr_i[MOD_HI:MOD_LO];
  assign fields_o.local_bus_target_bits = addr_i[BB_HI:BB_LO];
  assign fields_o.internal_dest         = addr_i[INT_HI:INT_LO];
endmodule

// >>> rtl/iad_msg_accept.sv
// message acceptance decision for the two attached processors
// assumes acceptance registers and buffer-free levels are stable
`timescale 1ns/1ps
module iad_msg_accept (
  // message
  input  wire logic       [4:0] prio_i,
  input  wire logic             sel_i,
  // per processor state
  input  wire logic       [8:0] acc0_i,
  input  wire logic       [8:0] acc1_i,
  input  wire logic       [1:0] buf_free_i,
  // decision
  output logic                  accept_o
);
  import iad_pkg::*;

  logic [8:0] acc_w;
  logic       prio_ok_w;

  // (RL16) target processor register
  assign acc_w     = sel_i ? acc1_i : acc0_i;
  // (RL17) zero lowest, 31 highest
  assign prio_ok_w = (prio_i >= acc_w[PRIO_HI-PRIO_LO:0]);
  // (RL3) low priority or full buffer refuses
  assign accept_o  = acc_w[ACC_EN_BIT] & prio_ok_w & buf_free_i[sel_i];
endmodule

// >>> rtl/iad_pkg.sv
// package for the interagent address decoder of a bus exchange unit
// assumes a single 40 MHz system clock and apb register access
//
// Operation
// (RL1) three refusal kinds: retry, nack, failed
// (RL2) retry on locked segment or blocked io
// (RL3) nack only for interagent transactions
// (RL4) requester timeout places failed reply itself
// (RL5) requester should not repeat failed access
// (RL6) failed reply legal for every request
// (RL7) top address byte all ones means interagent
// (RL8) low 24 bits split into four fields
// (RL9) originating unit acts itself or forwards
// (RL10) only message bus unit forwards messages
// (RL11) local bus target bits pick unit
// (RL12) decode the four bit type field
// (RL13) type 1111 always ignored
// (RL14) unit bits compared with logical identifier
// (RL15) processor select bit picks processor
// (RL16) acceptance register of target processor decides
// (RL17) five bit priority drives accept decision
// (RL18) message addresses sixteen byte aligned
// (RL19) test access consults agent select register
// (RL20) one word aligned register per request
// (RL21) command requests discard their data word
// (RL22) size mismatch gets nack, byte enables ignored
// (RL23) physical request compares hardwired identifier
// (RL24) bad local register request raises failed signal; code ignores local reads unless message bus unit
// (RL25) unmatched requests untouched, no reply
package iad_pkg;

  // ----------------------------------------------------------------
  // address fields
  // ----------------------------------------------------------------
  localparam logic [7:0] IAC_ID_VAL  = 8'hff;
  localparam int         ID_HI       = 31;
  localparam int         ID_LO       = 24;
  localparam int         TY_HI       = 23;
  localparam int         TY_LO       = 20;
  localparam int         MOD_HI      = 19;
  localparam int         MOD_LO      = 12;
  localparam int         BB_HI       = 11;
  localparam int         BB_LO       = 10;
  localparam int         INT_HI      = 9;
  localparam int         INT_LO      = 0;
  localparam int         UNIT_HI     = 7;
  localparam int         UNIT_LO     = 2;
  localparam int         SEL_BIT     = 1;
  localparam int         PRIO_HI     = 8;
  localparam int         PRIO_LO     = 4;
  localparam int         CMD_BIT     = 7;
  localparam logic [2:0] REG_WORDS   = 3'h1;

  localparam logic [3:0] T_LBREG     = 4'h0;
  localparam logic [3:0] T_LOG       = 4'h2;
  localparam logic [3:0] T_MSG       = 4'h3;
  localparam logic [3:0] T_PHY       = 4'h4;
  localparam logic [3:0] T_IDENT     = 4'h7;
  localparam logic [3:0] T_PRIV      = 4'hf;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_LOGID   = 8'h04;
  localparam logic [7:0] OFS_HWID    = 8'h08;
  localparam logic [7:0] OFS_ACC0    = 8'h0c;
  localparam logic [7:0] OFS_ACC1    = 8'h10;
  localparam logic [7:0] OFS_AGSEL   = 8'h14;
  localparam logic [7:0] OFS_STATUS  = 8'h18;
  localparam int         ACC_EN_BIT  = 8;
  localparam logic [2:0] CTRL_RST    = 3'h0;
  localparam logic [5:0] LOGID_RST   = 6'h00;
  localparam logic [8:0] ACC_RST     = 9'h000;
  localparam logic [5:0] HWID_DEF    = 6'h00;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    K_ACCEPT = 2'h0,
    K_RETRY  = 2'h1,
    K_NACK   = 2'h2,
    K_FAILED = 2'h3
  } iad_kind_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'h1,
    S_WAIT = 3'h2,
    S_DONE = 3'h4
  } iad_state_t;

  typedef struct packed {
    logic [3:0] ty;
    logic [7:0] module_dest;
    logic [1:0] local_bus_target_bits;
    logic [9:0] internal_dest;
  } iad_fields_t;

  typedef struct packed {
    logic      valid;
    iad_kind_t kind;
  } iad_reply_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        is_cmd;
    logic [7:0]  index;
    logic [31:0] data;
  } iad_regop_t;

endpackage

// >>> rtl/interagent_address_decode.sv
// interagent address decoder: local bus side, message bus side, apb
// assumes local bus requester holds its request until answered
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
module interagent_address_decode #(
  parameter int TIMEOUT_CYCLES = 256,
  parameter logic [5:0] HWID   = iad_pkg::HWID_DEF
) (
  // clock and reset
  input  wire logic                  CLK_SYS_I,
  input  wire logic                  RESET_I,
  // apb slave
  input  wire logic                  PSEL_I,
  input  wire logic                  PENABLE_I,
  input  wire logic                  PWRITE_I,
  input  wire logic           [7:0]  PADDR_I,
  input  wire logic           [31:0] PWDATA_I,
  output logic                [31:0] PRDATA_O,
  output logic                       PREADY_O,
  output logic                       PSLVERR_O,
  // local bus request and answer
  input  wire logic                  LB_REQ_I,
  input  wire logic           [31:0] LB_ADDR_I,
  input  wire logic                  LB_WRITE_I,
  input  wire logic           [2:0]  LB_WORDS_I,
  input  wire logic           [3:0]  LB_BE_I,
  input  wire logic           [31:0] LB_DATA_I,
  output logic                       LB_READY_O,
  output logic                       LB_FAIL_O,
  output iad_pkg::iad_kind_t         LB_KIND_O,
  // forward onto system message bus
  output logic                       SMB_FWD_VALID_O,
  output logic                [31:0] SMB_FWD_ADDR_O,
  output logic                       SMB_FWD_WRITE_O,
  output logic                [2:0]  SMB_FWD_WORDS_O,
  output logic                [31:0] SMB_FWD_DATA_O,
  input  wire logic                  SMB_RSP_VALID_I,
  input  wire iad_pkg::iad_kind_t    SMB_RSP_KIND_I,
  // requests arriving from system message bus
  input  wire logic                  SMB_REQ_I,
  input  wire logic           [31:0] SMB_ADDR_I,
  input  wire logic                  SMB_WRITE_I,
  input  wire logic           [2:0]  SMB_WORDS_I,
  input  wire logic           [31:0] SMB_DATA_I,
  input  wire logic                  SMB_LOCKED_READ_I,
  input  wire logic                  SMB_SEG_LOCKED_I,
  input  wire logic                  SMB_MMIO_I,
  input  wire logic                  SMB_IO_BLOCKED_I,
  input  wire logic           [1:0]  SMB_BUF_FREE_I,
  output iad_pkg::iad_reply_t        SMB_REPLY_O,
  // local actions
  output iad_pkg::iad_regop_t        REG_OP_O,
  output logic                [1:0]  MSG_TAKEN_O
);
  import iad_pkg::*;

  localparam int CW = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic [CW-1:0] TO_LOAD = CW'(TIMEOUT_CYCLES - 1);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // (RL20) one word register per request
  function automatic iad_regop_t mk_regop(input iad_fields_t f,
                                          input logic        wr,
                                          input logic [31:0] dat);
    iad_regop_t r;
    r.valid  = 1'b1;
    r.write  = wr;
    r.index  = f.internal_dest[INT_HI:2];
    r.is_cmd = r.index[CMD_BIT];
    // (RL21) command drops data word
    r.data   = r.is_cmd ? 32'h0 : dat;
    return r;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  iad_state_t  st_q, st_d;
  logic [2:0]  ctrl_q;
  logic [5:0]  logid_q;
  logic [8:0]  acc0_q, acc1_q;
  logic        agsel_q;
  logic [CW-1:0] cnt_q;
  iad_kind_t   last_kind_q;

  logic        msg_bus_w;
  logic [1:0]  bus_id_w;
  assign msg_bus_w = ctrl_q[0];
  assign bus_id_w  = ctrl_q[2:1];

  // ----------------------------------------------------------------
  // local bus decode
  // ----------------------------------------------------------------
  logic        lb_iac_w;
  iad_fields_t lb_f;
  logic        lb_take_w, lb_local_go_w, lb_fwd_go_w, lb_fwd_ok_w;
  logic        lb_size_bad_w, lb_bb_hit_w, lb_local_w;

  iad_field_split u_lb_split (
    .addr_i   (LB_ADDR_I),
    .is_iac_o (lb_iac_w),
    .fields_o (lb_f)
  );

  // (RL13) private space never taken
  assign lb_take_w = LB_REQ_I & lb_iac_w & (lb_f.ty != T_PRIV)
                     & (st_q == S_IDLE);
  // (RL11) unit picked by attached bus
  assign lb_bb_hit_w = (lb_f.local_bus_target_bits == bus_id_w);
  // (RL10) messages only via message bus unit
  assign lb_fwd_ok_w = (lb_f.ty == T_MSG) ? msg_bus_w
                       : (((lb_f.ty == T_LOG) | (lb_f.ty == T_PHY)
                          | (lb_f.ty == T_IDENT)) & lb_bb_hit_w);
  assign lb_local_w  = (lb_f.ty == T_LBREG);
  // (RL22) byte enables play no part
  assign lb_size_bad_w = (LB_WORDS_I != REG_WORDS);

  // ----------------------------------------------------------------
  // system bus serving decode
  // ----------------------------------------------------------------
  logic        sm_iac_w, unit_hit_w, phys_hit_w, sm_size_bad_w;
  logic        sm_retry_w, sm_msg_w, sm_reg_hit_w, sm_serve_reg_w;
  logic        serve_w, msg_ok_w, sm_sel_w;
  iad_fields_t sm_f;
  iad_kind_t   serve_kind_w;

  iad_field_split u_sm_split (
    .addr_i   (SMB_ADDR_I),
    .is_iac_o (sm_iac_w),
    .fields_o (sm_f)
  );

  assign sm_sel_w = sm_f.module_dest[SEL_BIT];

  iad_msg_accept u_accept (
    .prio_i     (sm_f.internal_dest[PRIO_HI:PRIO_LO]),
    .sel_i      (sm_sel_w),
    .acc0_i     (acc0_q),
    .acc1_i     (acc1_q),
    .buf_free_i (SMB_BUF_FREE_I),
    .accept_o   (msg_ok_w)
  );

  // (RL14) unit bits against logical identifier
  assign unit_hit_w = (sm_f.module_dest[UNIT_HI:UNIT_LO] == logid_q);
  // (RL23) low two bits ignored
  assign phys_hit_w = (sm_f.module_dest[UNIT_HI:UNIT_LO] == HWID);
  assign sm_size_bad_w = (SMB_WORDS_I != REG_WORDS);
  // (RL2) lock or blocked io
  assign sm_retry_w = SMB_REQ_I & ~sm_iac_w
                      & ((SMB_LOCKED_READ_I & SMB_SEG_LOCKED_I)
                         | (SMB_MMIO_I & SMB_IO_BLOCKED_I));
  // (RL12) message type on message bus
  assign sm_msg_w = SMB_REQ_I & sm_iac_w & (sm_f.ty == T_MSG)
                    & msg_bus_w & unit_hit_w;
  // (RL19) test access gated by agent select
  assign sm_reg_hit_w = SMB_REQ_I & sm_iac_w
                        & (((sm_f.ty == T_LOG) & unit_hit_w
                            & (~sm_f.module_dest[SEL_BIT] | agsel_q))
                           | ((sm_f.ty == T_PHY) & phys_hit_w));
  assign sm_serve_reg_w = sm_reg_hit_w & ~sm_size_bad_w;
  // (RL25) nothing matched, nothing driven
  assign serve_w = sm_retry_w | sm_msg_w | sm_reg_hit_w;
  // (RL1) distinct refusal reasons
  assign serve_kind_w = sm_retry_w ? K_RETRY
                      : sm_msg_w ? (msg_ok_w ? K_ACCEPT : K_NACK)
                      : (sm_size_bad_w ? K_NACK : K_ACCEPT);

  // a served register request wins over a local one in the same cycle
  assign lb_local_go_w = lb_take_w & lb_local_w & ~sm_serve_reg_w
                         & (LB_WRITE_I | msg_bus_w);
  // (RL9) forward or act locally
  assign lb_fwd_go_w = lb_take_w & ~lb_local_w & lb_fwd_ok_w;

  // ----------------------------------------------------------------
  // local bus sequencer
  // ----------------------------------------------------------------
  logic expire_w, rsp_w;
  assign rsp_w    = (st_q == S_WAIT) & SMB_RSP_VALID_I;
  // timeout yields to a serving reply in the same cycle
  assign expire_w = (st_q == S_WAIT) & ~SMB_RSP_VALID_I
                    & (cnt_q == '0) & ~serve_w;

  always_comb begin
    st_d = st_q;
    case (st_q)
      S_IDLE: begin
        if (lb_fwd_go_w) begin
          st_d = S_WAIT;
        end else if (lb_local_go_w) begin
          st_d = S_DONE;
        end
      end
      S_WAIT: begin
        if (rsp_w | expire_w) begin
          st_d = S_DONE;
        end
      end
      S_DONE: st_d = S_IDLE;
      default: st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      st_q  <= S_IDLE;
      cnt_q <= '0;
    end else begin
      st_q <= st_d;
      if (lb_fwd_go_w) begin
        cnt_q <= TO_LOAD;
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - CW'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // answers
  // ----------------------------------------------------------------
  iad_kind_t  lb_kind_d;
  logic       lb_done_d;
  iad_reply_t reply_d;
  iad_regop_t regop_d;

  assign lb_done_d = rsp_w | expire_w | lb_local_go_w;
  // (RL6) any reply kind closes the wait
  // (RL24) bad local register write fails; a read only on message bus unit
  assign lb_kind_d = rsp_w ? SMB_RSP_KIND_I
                   : expire_w ? K_FAILED
                   : (lb_size_bad_w ? K_FAILED : K_ACCEPT);
  // (RL4) requester drives failed reply itself
  assign reply_d.valid = serve_w | expire_w;
  assign reply_d.kind  = serve_w ? serve_kind_w : K_FAILED;
  assign regop_d = sm_serve_reg_w ? mk_regop(sm_f, SMB_WRITE_I, SMB_DATA_I)
                 : (lb_local_go_w & ~lb_size_bad_w)
                   ? mk_regop(lb_f, LB_WRITE_I, LB_DATA_I) : '0;

  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      LB_READY_O      <= 1'b0;
      LB_FAIL_O       <= 1'b0;
      LB_KIND_O       <= K_ACCEPT;
      last_kind_q     <= K_ACCEPT;
      SMB_REPLY_O     <= '0;
      REG_OP_O        <= '0;
      MSG_TAKEN_O     <= 2'h0;
      SMB_FWD_VALID_O <= 1'b0;
      SMB_FWD_ADDR_O  <= 32'h0;
      SMB_FWD_WRITE_O <= 1'b0;
      SMB_FWD_WORDS_O <= 3'h0;
      SMB_FWD_DATA_O  <= 32'h0;
    end else begin
      LB_READY_O  <= lb_done_d & (lb_kind_d == K_ACCEPT);
      LB_FAIL_O   <= lb_done_d & (lb_kind_d != K_ACCEPT);
      LB_KIND_O   <= lb_done_d ? lb_kind_d : K_ACCEPT;
      if (lb_done_d) begin
        last_kind_q <= lb_kind_d;
      end
      SMB_REPLY_O <= reply_d;
      REG_OP_O    <= regop_d;
      // (RL15) select bit picks processor
      MSG_TAKEN_O <= (sm_msg_w & msg_ok_w)
                     ? (sm_sel_w ? 2'h2 : 2'h1) : 2'h0;
      SMB_FWD_VALID_O <= lb_fwd_go_w;
      if (lb_fwd_go_w) begin
        SMB_FWD_ADDR_O  <= LB_ADDR_I;
        SMB_FWD_WRITE_O <= LB_WRITE_I;
        SMB_FWD_WORDS_O <= LB_WORDS_I;
        SMB_FWD_DATA_O  <= LB_DATA_I;
      end
    end
  end

  // ----------------------------------------------------------------
  // apb registers
  // ----------------------------------------------------------------
  // one wait state keeps read data straight from a flop
  logic        acc_w, wr_w, hit_w;
  logic [31:0] rd_w;
  assign acc_w = PSEL_I & PENABLE_I & ~PREADY_O;
  assign wr_w  = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I & hit_w;
  assign hit_w = (PADDR_I == OFS_CTRL) | (PADDR_I == OFS_LOGID)
               | (PADDR_I == OFS_HWID) | (PADDR_I == OFS_ACC0)
               | (PADDR_I == OFS_ACC1) | (PADDR_I == OFS_AGSEL)
               | (PADDR_I == OFS_STATUS);

  always_comb begin
    rd_w = 32'h0;
    case (PADDR_I)
      OFS_CTRL:   rd_w = {29'h0, ctrl_q};
      OFS_LOGID:  rd_w = {26'h0, logid_q};
      OFS_HWID:   rd_w = {26'h0, HWID};
      OFS_ACC0:   rd_w = {23'h0, acc0_q};
      OFS_ACC1:   rd_w = {23'h0, acc1_q};
      OFS_AGSEL:  rd_w = {31'h0, agsel_q};
      OFS_STATUS: rd_w = {29'h0, (st_q == S_WAIT), last_kind_q};
      default:    rd_w = 32'h0;
    endcase
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O  <= 32'h0;
      ctrl_q    <= CTRL_RST;
      logid_q   <= LOGID_RST;
      acc0_q    <= ACC_RST;
      acc1_q    <= ACC_RST;
      agsel_q   <= 1'b0;
    end else begin
      PREADY_O  <= acc_w;
      PSLVERR_O <= acc_w & ~hit_w;
      PRDATA_O  <= (acc_w & ~PWRITE_I) ? rd_w : 32'h0;
      if (wr_w && PADDR_I == OFS_CTRL)  ctrl_q  <= PWDATA_I[2:0];
      if (wr_w && PADDR_I == OFS_LOGID) logid_q <= PWDATA_I[5:0];
      if (wr_w && PADDR_I == OFS_ACC0)  acc0_q  <= PWDATA_I[8:0];
      if (wr_w && PADDR_I == OFS_ACC1)  acc1_q  <= PWDATA_I[8:0];
      if (wr_w && PADDR_I == OFS_AGSEL) agsel_q <= PWDATA_I[0];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RESET_I);

  sequence s_expire;
    (st_q == S_WAIT) && !SMB_RSP_VALID_I && (cnt_q == '0) && !serve_w;
  endsequence
  sequence s_failed_out;
    SMB_REPLY_O.valid && (SMB_REPLY_O.kind == K_FAILED) && LB_FAIL_O;
  endsequence

  a_timeout_failed: assert property (s_expire |=> s_failed_out) // (RL4)
    else $error("timeout did not give failed reply");
  a_private_drop: assert property ( // (RL13)
    LB_REQ_I && lb_iac_w && (lb_f.ty == T_PRIV) |=> !SMB_FWD_VALID_O)
    else $error("private space forwarded");
  a_fwd_copy: assert property ( // (RL9)
    lb_fwd_go_w |=> SMB_FWD_VALID_O && (SMB_FWD_ADDR_O == $past(LB_ADDR_I))
    ##1 !SMB_FWD_VALID_O)
    else $error("forward not a one cycle copy");
  a_retry_lock: assert property ( // (RL2)
    SMB_REQ_I && !sm_iac_w && SMB_LOCKED_READ_I && SMB_SEG_LOCKED_I
    |=> SMB_REPLY_O.valid && (SMB_REPLY_O.kind == K_RETRY))
    else $error("locked read not retried");
  a_size_nack: assert property ( // (RL22)
    sm_reg_hit_w && sm_size_bad_w
    |=> SMB_REPLY_O.valid && (SMB_REPLY_O.kind == K_NACK))
    else $error("size mismatch not refused");
  a_prio_nack: assert property ( // (RL17)
    sm_msg_w && !msg_ok_w |=> (SMB_REPLY_O.kind == K_NACK)
                              && (MSG_TAKEN_O == 2'h0))
    else $error("refused message delivered");
  a_cmd_discard: assert property ( // (RL21)
    REG_OP_O.valid && REG_OP_O.is_cmd |-> REG_OP_O.data == 32'h0)
    else $error("command kept data");
  a_local_fail: assert property ( // (RL24)
    lb_local_go_w && lb_size_bad_w |=> LB_FAIL_O && !LB_READY_O
                                       && !REG_OP_O.valid)
    else $error("bad local request not failed");
  a_no_match: assert property ( // (RL25)
    SMB_REQ_I && sm_iac_w && !serve_w && !lb_local_go_w
    |=> !REG_OP_O.valid && (MSG_TAKEN_O == 2'h0))
    else $error("unmatched request acted on");
endmodule
